// ==== sfcsr_pkg.sv ====
// Package: field layout, reset values and carriers of the SIMD FP control/status register
package sfcsr_pkg;

  // Field positions
  localparam int FLAG_LSB  = 0;
  localparam int DAZ_BIT   = 6;
  localparam int MASK_LSB  = 7;
  localparam int RND_LSB   = 13;
  localparam int FTZ_BIT   = 15;
  localparam int RSVD_LSB  = 16;
  localparam int NUM_EXC   = 6;

  // Exception order inside flag and mask groups
  localparam int EXC_INVALID   = 0;
  localparam int EXC_DENORMAL  = 1;
  localparam int EXC_DIVZERO   = 2;
  localparam int EXC_OVERFLOW  = 3;
  localparam int EXC_UNDERFLOW = 4;
  localparam int EXC_PRECISION = 5;

  // Value after reset: all masks set, everything else clear
  localparam logic [31:0] CSR_RESET = 32'h0000_1F80;
  localparam logic [31:0] RSVD_BITS = 32'hFFFF_0000;
  localparam logic [31:0] DAZ_MASK  = 32'h0000_0040;

  typedef enum logic [1:0] {
    SFCSR_RND_NEAREST = 2'h0,
    SFCSR_RND_DOWN    = 2'h1,
    SFCSR_RND_UP      = 2'h2,
    SFCSR_RND_ZERO    = 2'h3
  } sfcsr_rnd_t;

  // Register image
  typedef struct packed {
    logic [15:0]        reserved;
    logic               ftz;
    sfcsr_rnd_t         rnd;
    logic [NUM_EXC-1:0] mask;
    logic               denormals_zero_enable;
    logic [NUM_EXC-1:0] flag;
  } sfcsr_reg_t;

  // Datapath report for one completed instruction
  typedef struct packed {
    logic               valid;
    logic [NUM_EXC-1:0] detect;
  } sfcsr_report_t;

  // Controls shown to the datapath
  typedef struct packed {
    sfcsr_rnd_t         rnd;
    logic               flush_underflow;
    logic               denormals_zero;
    logic [NUM_EXC-1:0] mask;
  } sfcsr_ctrl_t;

endpackage

// ==== sfcsr_exc_filter.sv ====
// Filter of datapath exception reports under the current modes
`timescale 1ns/100ps
module sfcsr_exc_filter
  import sfcsr_pkg::*;
(
  // Current register
  input  wire sfcsr_pkg::sfcsr_reg_t    csr,
  // Raw report
  input  wire sfcsr_pkg::sfcsr_report_t report,
  // Flags to set and faults to raise
  output logic [sfcsr_pkg::NUM_EXC-1:0] set_flags,
  output logic [sfcsr_pkg::NUM_EXC-1:0] raise
);
  logic [NUM_EXC-1:0] det;
  logic               ftz_act;

  always_comb begin
    det = report.valid ? report.detect : '0;
    ftz_act = csr.ftz && csr.mask[EXC_UNDERFLOW];
    if (csr.denormals_zero_enable) begin
      det[EXC_DENORMAL] = 1'b0;
    end
    if (ftz_act && det[EXC_UNDERFLOW]) begin
      det[EXC_PRECISION] = 1'b1;
    end
    set_flags = det;
    raise     = det & ~csr.mask;
  end
endmodule

// ==== sfcsr_top.sv ====
// SIMD FP control/status register with load/store/save/restore ports
`timescale 1ns/100ps
//==============================================================
module sfcsr_top
  import sfcsr_pkg::*;
#(
  parameter bit DAZ_SUPPORTED = 1'b1
)
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  // Register write: load or full-state restore
  input  wire logic                  register_load_instr,
  input  wire logic                  full_state_restore_instr,
  input  wire logic [31:0]           wr_data,
  // Register read: store or full-state save
  input  wire logic                  register_store_instr,
  input  wire logic                  full_state_save_instr,
  output logic [31:0]                rd_data,
  output logic [31:0]                supported_bits_mask,
  output logic                       rd_valid,
  // Datapath
  input  wire sfcsr_pkg::sfcsr_report_t dp_report,
  output sfcsr_pkg::sfcsr_ctrl_t     dp_ctrl,
  output logic [NUM_EXC-1:0]         simd_fp_exception,
  output logic                       general_protection_fault
);
  import sfcsr_pkg::*;

  //==============================================================
  // State
  typedef struct packed {
    sfcsr_reg_t         csr;
    logic [31:0]        rd;
    logic               rdv;
    logic [NUM_EXC-1:0] exc;
    logic               gp;
  } sfcsr_state_t;

  localparam sfcsr_state_t ST_RESET = '{
    csr: sfcsr_reg_t'(CSR_RESET), rd: 32'h0000_0000, rdv: 1'b0,
    exc: '0, gp: 1'b0};

  sfcsr_state_t       st_r;
  sfcsr_state_t       st_nxt;
  logic [NUM_EXC-1:0] set_flags;
  logic [NUM_EXC-1:0] raise;
  logic               wr_req;
  logic               wr_bad;
  logic [31:0]        valid_bits;

  function automatic logic [31:0] sfcsr_valid_bits(input bit daz_ok);
    return daz_ok ? ~RSVD_BITS : (~RSVD_BITS & ~DAZ_MASK);
  endfunction

  sfcsr_exc_filter u_filter (
    .csr       (st_r.csr),
    .report    (dp_report),
    .set_flags (set_flags),
    .raise     (raise)
  );

  //==============================================================
  // Next state
  always_comb begin
    st_nxt     = st_r;
    valid_bits = sfcsr_valid_bits(DAZ_SUPPORTED);
    wr_req     = register_load_instr || full_state_restore_instr;
    wr_bad     = |(wr_data & ~valid_bits);
    st_nxt.gp  = wr_req && wr_bad;
    st_nxt.exc = raise;
    // Datapath events set flags; a legal write replaces the image but keeps same-cycle datapath flags
    st_nxt.csr.flag = st_r.csr.flag | set_flags;
    if (wr_req && !wr_bad) begin
      st_nxt.csr = sfcsr_reg_t'(wr_data);
      st_nxt.csr.flag = wr_data[NUM_EXC-1:0] | set_flags;
    end
    st_nxt.csr.reserved = '0;
    if (!DAZ_SUPPORTED) begin
      st_nxt.csr.denormals_zero_enable = 1'b0;
    end
    st_nxt.rdv = register_store_instr || full_state_save_instr;
    if (st_nxt.rdv) begin
      st_nxt.rd = st_r.csr;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  //==============================================================
  // Outputs
  assign rd_data                  = st_r.rd;
  assign rd_valid                 = st_r.rdv;
  assign supported_bits_mask      = sfcsr_valid_bits(DAZ_SUPPORTED);
  assign simd_fp_exception        = st_r.exc;
  assign general_protection_fault = st_r.gp;
  assign dp_ctrl.rnd              = st_r.csr.rnd;
  assign dp_ctrl.flush_underflow  =
    st_r.csr.ftz && st_r.csr.mask[EXC_UNDERFLOW];
  assign dp_ctrl.denormals_zero   = st_r.csr.denormals_zero_enable;
  assign dp_ctrl.mask             = st_r.csr.mask;
endmodule

// ==== sfcsr_dp_model.sv ====
// Datapath stand-in that issues exception reports
`timescale 1ns/100ps
module sfcsr_dp_model
  import sfcsr_pkg::*;
(
  // Clock and command
  input  wire logic                sys_clk,
  input  wire logic                go,
  input  wire logic [5:0]          det,
  // Report to the register
  output sfcsr_pkg::sfcsr_report_t dp_report
);
  initial dp_report = '0;
  // Idle report carries flipped detect bits
  always @(posedge sys_clk) begin
    dp_report.valid <= go;
    dp_report.detect <= go ? det : ~dp_report.detect;
  end
endmodule

// ==== sfcsr_checker.sv ====
// Port checker of the SIMD FP control/status register
`timescale 1ns/100ps
module sfcsr_checker
  import sfcsr_pkg::*;
(
  // Top ports
  input wire logic                     sys_clk,
  input wire logic                     resetn,
  input wire logic                     register_load_instr,
  input wire logic                     full_state_restore_instr,
  input wire logic [31:0]              wr_data,
  input wire logic                     register_store_instr,
  input wire logic                     full_state_save_instr,
  input wire logic [31:0]              rd_data,
  input wire logic [31:0]              supported_bits_mask,
  input wire logic                     rd_valid,
  input wire sfcsr_pkg::sfcsr_report_t dp_report,
  input wire sfcsr_pkg::sfcsr_ctrl_t   dp_ctrl,
  input wire logic [5:0]               simd_fp_exception,
  input wire logic                     general_protection_fault
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire logic wr = register_load_instr | full_state_restore_instr;
  wire logic ok = wr && !(|(wr_data & ~supported_bits_mask));
  bad_write_gp_a: assert property (wr && !ok |=> general_protection_fault)
    else $error("no fault");
  read_answer_a: assert property (
    register_store_instr | full_state_save_instr |=> rd_valid)
    else $error("no read data");
  mask_load_a: assert property (
    ok |=> dp_ctrl.mask == $past(wr_data[12:7])) else $error("mask");
  rnd_load_a: assert property (
    ok |=> dp_ctrl.rnd == $past(wr_data[14:13])) else $error("rnd");
  no_idle_raise_a: assert property (
    !dp_report.valid |=> simd_fp_exception == 6'h00) else $error("raise");
  masked_quiet_a: assert property (
    1'b1 |=> (simd_fp_exception & $past(dp_ctrl.mask)) == 6'h00)
    else $error("masked raise");
  unmask_raise_a: assert property (
    dp_report.valid && dp_report.detect[2] && !dp_ctrl.mask[2]
    |=> simd_fp_exception[2]) else $error("no raise");
  daz_quiet_a: assert property (
    dp_ctrl.denormals_zero |=> !simd_fp_exception[1]) else $error("daz");
  reset_ctrl_a: assert property (
    $rose(resetn) |-> dp_ctrl == 10'h03F) else $error("reset ctrl");
  cover property (|simd_fp_exception);
  cover property (general_protection_fault);
  cover property (rd_valid);
endmodule

// ==== sfcsr_tb_top.sv ====
// Testbench of the SIMD FP control/status register
`timescale 1ns/100ps
module sfcsr_tb_top;
  import sfcsr_pkg::*;
  logic sys_clk = 1'b0, resetn = 1'b0, ld = 0, rs = 0, st = 0, sv = 0;
  logic go = 0, rdv, gp;
  logic [31:0] wd = 32'h0, rdd, sbm;
  logic [5:0] det = 6'h00, exc;
  sfcsr_report_t rep;
  sfcsr_ctrl_t ctrl;
  int miscompares = 0, tests_run = 0;
  always #2 sys_clk = ~sys_clk;
  sfcsr_top u_dut(.sys_clk(sys_clk), .resetn(resetn),
    .register_load_instr(ld), .full_state_restore_instr(rs),
    .wr_data(wd), .register_store_instr(st),
    .full_state_save_instr(sv), .rd_data(rdd),
    .supported_bits_mask(sbm), .rd_valid(rdv), .dp_report(rep),
    .dp_ctrl(ctrl), .simd_fp_exception(exc),
    .general_protection_fault(gp));
  sfcsr_dp_model u_dp(.sys_clk(sys_clk), .go(go), .det(det),
    .dp_report(rep));
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] ex);
    tests_run++;
    if (seen !== ex) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic wr(logic [31:0] d, logic s, logic g);
    @(posedge sys_clk);
    ld <= !s;
    rs <= s;
    wd <= d;
    @(posedge sys_clk);
    ld <= 1'b0;
    rs <= 1'b0;
    #1 chk("gp", gp, g);
  endtask
  task automatic rd(logic [31:0] e, logic s);
    @(posedge sys_clk);
    st <= !s;
    sv <= s;
    @(posedge sys_clk);
    st <= 1'b0;
    sv <= 1'b0;
    #1 chk("rdv", rdv, 1);
    chk("rd", rdd, e);
  endtask
  task automatic dp(logic [5:0] d, logic [5:0] e);
    @(posedge sys_clk);
    go <= 1'b1;
    det <= d;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    #1 chk("exc", exc, e);
  endtask
  task automatic give_verdict();
    $display("checks %0d bad %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    chk("sbm", sbm, 32'h0000_FFFF);
    rd(32'h0000_1F80, 0);
    for (int r = 0; r < 4; r++) begin
      wr({16'h0, 1'b0, r[1:0], 13'h1F80}, r[0], 0);
      chk("rnd", ctrl.rnd, r[1:0]);
      rd({16'h0, 1'b0, r[1:0], 13'h1F80}, r[1]);
    end
    wr(32'h0001_0000, 0, 1);
    rd(32'h0000_7F80, 1);
    wr(32'h0000_0001, 1, 0);
    chk("exc", exc, 6'h00);
    dp(6'h10, 6'h10);
    dp(6'h00, 6'h00);
    rd(32'h0000_0011, 0);
    wr(32'h0000_0000, 0, 0);
    rd(32'h0000_0000, 1);
    wr(32'h0000_9F80, 1, 0);
    chk("ftz", ctrl.flush_underflow, 1);
    dp(6'h10, 6'h00);
    rd(32'h0000_9FB0, 0);
    wr(32'h0000_1EC0, 0, 0);
    chk("daz", ctrl.denormals_zero, 1);
    dp(6'h02, 6'h00);
    rd(32'h0000_1EC0, 1);
    // Unmasked underflow ignores flush enable
    wr(32'h0000_8000, 0, 0);
    chk("ftz", ctrl.flush_underflow, 0);
    dp(6'h10, 6'h10);
    rd(32'h0000_8010, 1);
    // Reset again in mid-run
    @(posedge sys_clk);
    resetn <= 1'b0;
    @(posedge sys_clk);
    resetn <= 1'b1;
    rd(32'h0000_1F80, 0);
    chk("msk", ctrl.mask, 6'h3F);
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    give_verdict();
  end
endmodule
bind sfcsr_top sfcsr_checker u_chk(.*);
